// ==== verilog/alarm_clear_map.svh ====
`ifndef ALARM_CLEAR_MAP_SVH
`define ALARM_CLEAR_MAP_SVH
// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define ACI_OFF_GAIN      12'h000
`define ACI_OFF_USAGE     12'h004
`define ACI_OFF_MODE      12'h008
`define ACI_OFF_HWEN      12'h00c
`define ACI_OFF_CTRL      12'h010
`define ACI_OFF_STATUS    12'h014
`define ACI_OFF_REPLY     12'h018
`define ACI_OFF_SAVED     12'h01c
// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define ACI_CTRL_SAVE_BIT   0
`define ACI_CTRL_RAISE_BIT  1
`define ACI_ST_ALARM_BIT    0
`define ACI_ST_ENABLE_BIT   1
`define ACI_ST_ARMED_BIT    2
`define ACI_ST_GPI_BIT      3
// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define ACI_RST_GAIN      16'h0000
`define ACI_RST_USAGE     2'h3
`define ACI_RST_POINT     3'h4
`define ACI_RST_MODE      8'h00
`define ACI_RST_HWEN      2'h0
`define ACI_CHAR_L        8'h4c
`define ACI_CHAR_H        8'h48
`define ACI_CHAR_ZERO     8'h30
`define ACI_GAIN_MAX      16'h7fff
`define ACI_GAIN_MIN      16'h8001
`endif

// ==== verilog/alarm_clear_pkg.sv ====
package alarm_clear_pkg;
    typedef enum logic [1:0] {
        USAGE_CLOSE = 2'h1,
        USAGE_OPEN  = 2'h2,
        USAGE_NONE  = 2'h3
    } usage_e;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_WAIT  = 3'b010,
        ST_ARMED = 3'b100
    } clr_state_e;
endpackage

// ==== verilog/edge_sampler.sv ====
`timescale 1ns/1ps
module edge_sampler (
    // Clock and reset
    input  wire logic MCLK_I,
    input  wire logic RESET_I,
    // Pin level and edges
    input  wire logic pin_i,
    output logic      level_o,
    output logic      fall_o,
    output logic      rise_o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } smp_s;
    smp_s q, d;
    always_comb begin
        d    = q;
        d.s1 = pin_i;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            q <= 3'b111;
        end else begin
            q <= d;
        end
    end
    // Two consecutive synchronised samples make an edge; s1 feeds only s2.
    assign level_o = q.s2;
    assign fall_o  = q.s3 & ~q.s2;
    assign rise_o  = ~q.s3 & q.s2;
endmodule

// ==== verilog/alarm_clear_input.sv ====
`timescale 1ns/1ps
`include "alarm_clear_map.svh"
// Function
// - Gain is signed, -32767..32767, quarter rpm.
// - Speed-change command modes disable alarm clear.
// - Later hardware enable setting 1 or 2 forces usage 3.
// - Usage 1 clears on falling edge only.
// - Usage 1 closed at alarm clears only after it opens first.
// - Usage 1 enables drive when input opens.
// - Usage 2 clears on rising edge only.
// - Usage 2 open at alarm clears only after it closes first.
// - Usage 2 enables drive when input closes.
// - Usage 3 leaves input general purpose.
// - Modes 13,14,17,18 or hardware enable 1 or 2 force 3.
// - Point selects I/O 2 or 4, input direction.
// - Resting return enables unless hardware enable set.
// - Query answers usage digit, then point digit on variable I/O only.
// - Energized means low, open means high.
// - Characters L and H name low and high.
// - Settings copied to saved set on save.
module alarm_clear_input #(
    parameter int GAIN_W = 16
) (
    // Clock and reset
    input  wire logic        MCLK_I,
    input  wire logic        RESET_I,
    // APB slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic [31:0]      PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // Pins
    input  wire logic        EN_PIN_I,
    input  wire logic [3:0]  IO_PIN_I,
    input  wire logic [3:0]  IO_DIR_IN_I,
    input  wire logic        VARIABLE_IO_I,
    input  wire logic        ALARM_RAISE_I,
    // Status outputs
    output logic             ALARM_O,
    output logic             DRIVE_ENABLE_O,
    output logic             GP_INPUT_O
);
    // ------------------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------------------
    // The saved copy packs the gain into the upper half of one read word.
    if (GAIN_W != 16) begin : g_gain_w_check
        $error("alarm_clear_input supports only a 16-bit gain");
    end

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [GAIN_W-1:0]         gain;
        alarm_clear_pkg::usage_e   usage;
        logic [2:0]                point;
        logic [7:0]                mode;
        logic [1:0]                hwen;
        logic [GAIN_W-1:0]         sv_gain;
        alarm_clear_pkg::usage_e   sv_usage;
        logic [2:0]                sv_point;
        alarm_clear_pkg::clr_state_e st;
        logic                      alarm;
        logic                      enable;
        logic                      wait_rest;
        logic [31:0]               rdata;
        logic                      slverr;
    } state_s;
    state_s q, d;

    logic sel_level;
    logic sel_fall;
    logic sel_rise;
    logic pin_mux;
    logic wr_acc;
    logic rd_acc;
    logic speed_mode;
    logic at_rest;
    logic clear_edge;
    logic [1:0] wusage;
    logic [2:0] wpoint;

    // ------------------------------------------------------------------------
    // Pin select
    // ------------------------------------------------------------------------
    // The pin level is already the logic level: energized reads low.
    // A point that was never accepted stays at its reset value, I/O 4.
    always_comb begin
        pin_mux = EN_PIN_I;
        if (VARIABLE_IO_I) begin
            pin_mux = (q.point == 3'h2) ? IO_PIN_I[1] : IO_PIN_I[3];
        end
    end

    // ------------------------------------------------------------------------
    // Edge sampling
    // ------------------------------------------------------------------------
    // Every decision below uses the synchronised copy, never the raw pin.
    edge_sampler u_edge (
        .MCLK_I  (MCLK_I),
        .RESET_I (RESET_I),
        .pin_i   (pin_mux),
        .level_o (sel_level),
        .fall_o  (sel_fall),
        .rise_o  (sel_rise)
    );

    // ------------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------------
    // Reads are decoded in the setup phase so the answer can come from a flop.
    assign wr_acc = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd_acc = PSEL_I & ~PENABLE_I & ~PWRITE_I;
    // Speed-change modes borrow the enable input, so they outrank the clear.
    assign speed_mode = (q.mode == 8'h0d) || (q.mode == 8'h0e) ||
                        (q.mode == 8'h11) || (q.mode == 8'h12);
    assign wusage = PWDATA_I[1:0];
    assign wpoint = PWDATA_I[6:4];

    // ------------------------------------------------------------------------
    // Resting level and clear edge
    // ------------------------------------------------------------------------
    // Resting level: open (high) for usage 1, closed (low) for usage 2.
    // Usage 3 has neither, so the sequence below can never arm.
    always_comb begin
        at_rest    = 1'b0;
        clear_edge = 1'b0;
        if (q.usage == alarm_clear_pkg::USAGE_CLOSE) begin
            at_rest    = sel_level;
            clear_edge = sel_fall;
        end else if (q.usage == alarm_clear_pkg::USAGE_OPEN) begin
            at_rest    = ~sel_level;
            clear_edge = sel_rise;
        end
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    always_comb begin
        d = q;
        d.slverr = 1'b0;
        // Register writes.
        if (wr_acc) begin
            if (PADDR_I == `ACI_OFF_GAIN) begin
                // -32768 is outside the range, so it is clamped to -32767.
                if (PWDATA_I[15:0] == 16'h8000) begin
                    d.gain = `ACI_GAIN_MIN;
                end else begin
                    d.gain = PWDATA_I[GAIN_W-1:0];
                end
            end else if (PADDR_I == `ACI_OFF_USAGE) begin
                if (wusage != 2'h0) begin
                    d.usage = alarm_clear_pkg::usage_e'(wusage);
                end
                // only points 2 and 4 that are inputs are accepted.
                if (VARIABLE_IO_I && (wpoint == 3'h2 || wpoint == 3'h4) &&
                    IO_DIR_IN_I[wpoint[1:0] - 2'h1]) begin
                    d.point = wpoint;
                end
                d.slverr = (wusage == 2'h0);
            end else if (PADDR_I == `ACI_OFF_MODE) begin
                d.mode = PWDATA_I[7:0];
                if (PWDATA_I[7:0] == 8'h0d || PWDATA_I[7:0] == 8'h0e ||
                    PWDATA_I[7:0] == 8'h11 || PWDATA_I[7:0] == 8'h12) begin
                    d.usage = alarm_clear_pkg::USAGE_NONE;
                end
            end else if (PADDR_I == `ACI_OFF_HWEN) begin
                d.hwen = PWDATA_I[1:0];
                // Hardware enable 1 or 2 takes the pin back, so the clear function is parked.
                if (PWDATA_I[1:0] == 2'h1 || PWDATA_I[1:0] == 2'h2) begin
                    d.usage = alarm_clear_pkg::USAGE_NONE;
                end
            end else if (PADDR_I == `ACI_OFF_CTRL) begin
                // Only a save touches the saved set; every other write is live only.
                if (PWDATA_I[`ACI_CTRL_SAVE_BIT]) begin
                    d.sv_gain  = q.gain;
                    d.sv_usage = q.usage;
                    d.sv_point = q.point;
                end
            end else if (PADDR_I == `ACI_OFF_STATUS || PADDR_I == `ACI_OFF_REPLY ||
                         PADDR_I == `ACI_OFF_SAVED) begin
                d.slverr = 1'b1;
            end else begin
                d.slverr = 1'b1;
            end
        end

        // Alarm clear sequence.
        // A raise restarts the sequence, so a clear edge in the same cycle is lost.
        if (ALARM_RAISE_I ||
            (wr_acc && PADDR_I == `ACI_OFF_CTRL && PWDATA_I[`ACI_CTRL_RAISE_BIT])) begin
            d.alarm  = 1'b1;
            d.enable = 1'b0;
            d.wait_rest = 1'b0;
            d.st     = alarm_clear_pkg::ST_WAIT;
        end else if (q.usage == alarm_clear_pkg::USAGE_NONE || speed_mode) begin
            d.st = alarm_clear_pkg::ST_IDLE;
        end else begin
            case (q.st)
                alarm_clear_pkg::ST_WAIT: begin
                    // Seen resting since the alarm before any edge counts.
                    if (at_rest) begin
                        d.st = alarm_clear_pkg::ST_ARMED;
                    end
                end
                alarm_clear_pkg::ST_ARMED: begin
                    // Enabling waits for the input's return to rest.
                    if (clear_edge) begin
                        d.alarm     = 1'b0;
                        d.wait_rest = 1'b1;
                        d.st        = alarm_clear_pkg::ST_IDLE;
                    end
                end
                default: begin
                    if (q.wait_rest && at_rest) begin
                        d.wait_rest = 1'b0;
                        // hardware enable owns the enable when assigned.
                        if (q.hwen == 2'h0) begin
                            d.enable = 1'b1;
                        end
                    end
                end
            endcase
        end

        // Read data is latched in the setup cycle so it comes from a flop.
        if (rd_acc) begin
            d.rdata = 32'h0000_0000;
            if (PADDR_I == `ACI_OFF_GAIN) begin
                d.rdata = {{(32-GAIN_W){q.gain[GAIN_W-1]}}, q.gain};
            end else if (PADDR_I == `ACI_OFF_USAGE) begin
                d.rdata = {25'h0, q.point, 2'h0, q.usage};
            end else if (PADDR_I == `ACI_OFF_MODE) begin
                d.rdata = {24'h0, q.mode};
            end else if (PADDR_I == `ACI_OFF_HWEN) begin
                d.rdata = {30'h0, q.hwen};
            end else if (PADDR_I == `ACI_OFF_STATUS) begin
                // The input level is shown as the same character a command would use.
                d.rdata = {20'h0,
                           (sel_level ? `ACI_CHAR_H : `ACI_CHAR_L),
                           q.usage == alarm_clear_pkg::USAGE_NONE,
                           q.st == alarm_clear_pkg::ST_ARMED,
                           q.enable, q.alarm};
            end else if (PADDR_I == `ACI_OFF_REPLY) begin
                // usage digit, then the point digit on variable I/O.
                d.rdata = VARIABLE_IO_I ?
                          {16'h0, `ACI_CHAR_ZERO + {6'h0, q.usage},
                           `ACI_CHAR_ZERO + {5'h0, q.point}} :
                          {24'h0, `ACI_CHAR_ZERO + {6'h0, q.usage}};
            end else if (PADDR_I == `ACI_OFF_SAVED) begin
                d.rdata = {q.sv_gain, 9'h0, q.sv_point, 2'h0, q.sv_usage};
            end else if (PADDR_I != `ACI_OFF_CTRL) begin
                d.slverr = 1'b1;
            end
        end else if (PSEL_I && PENABLE_I && !PWRITE_I) begin
            d.slverr = q.slverr;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // The synchronous reset leaves usage 3 with the drive enabled.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            q.gain      <= `ACI_RST_GAIN;
            q.usage     <= alarm_clear_pkg::USAGE_NONE;
            q.point     <= `ACI_RST_POINT;
            q.mode      <= `ACI_RST_MODE;
            q.hwen      <= `ACI_RST_HWEN;
            q.sv_gain   <= `ACI_RST_GAIN;
            q.sv_usage  <= alarm_clear_pkg::USAGE_NONE;
            q.sv_point  <= `ACI_RST_POINT;
            q.st        <= alarm_clear_pkg::ST_IDLE;
            q.alarm     <= 1'b0;
            q.enable    <= 1'b1;
            q.wait_rest <= 1'b0;
            q.rdata     <= 32'h0000_0000;
            q.slverr    <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Write errors never reach PSLVERR_O, which is gated to read access cycles; reads show in the access.
    // Zero wait states: every access finishes in its first access cycle.
    assign PREADY_O       = 1'b1;
    assign PRDATA_O       = q.rdata;
    assign PSLVERR_O      = PSEL_I & PENABLE_I & ~PWRITE_I & q.slverr;
    assign ALARM_O        = q.alarm;
    assign DRIVE_ENABLE_O = q.enable;
    assign GP_INPUT_O     = sel_level;
endmodule

// ==== verif/alarm_clear_input_props.sv ====
`timescale 1ns/1ps
`include "alarm_clear_map.svh"
module alarm_clear_input_props (
    // Clock, reset and bus
    input wire logic        MCLK_I,
    input wire logic        RESET_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [31:0] PRDATA_O,
    // Pins and status
    input wire logic        EN_PIN_I,
    input wire logic        VARIABLE_IO_I,
    input wire logic        ALARM_RAISE_I,
    input wire logic        ALARM_O,
    input wire logic        DRIVE_ENABLE_O,
    input wire logic        GP_INPUT_O
);
    logic       wr;
    logic       spd_q;
    logic       u3_q;
    logic       hw_q;
    logic [1:0] age_q;
    logic       spd;
    assign wr = PSEL_I & PENABLE_I & PWRITE_I;
    assign spd = PWDATA_I[7:0] inside {8'h0d, 8'h0e, 8'h11, 8'h12};
    // Shadow of the settings that block the clear path, so a clear while blocked is caught.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            spd_q <= 1'b0;
            u3_q <= 1'b1;
            hw_q <= 1'b0;
            age_q <= 2'h0;
        end else begin
            age_q <= (age_q == 2'h3) ? age_q : age_q + 2'h1;
            if (wr && PADDR_I == `ACI_OFF_USAGE && PWDATA_I[1:0] != 2'h0) begin
                u3_q <= PWDATA_I[1:0] == 2'h3;
            end
            if (wr && PADDR_I == `ACI_OFF_MODE) begin
                spd_q <= spd;
                u3_q <= u3_q | spd;
            end
            if (wr && PADDR_I == `ACI_OFF_HWEN) begin
                hw_q <= PWDATA_I[1:0] != 2'h0;
                u3_q <= u3_q | (PWDATA_I[1:0] == 2'h1) | (PWDATA_I[1:0] == 2'h2);
            end
        end
    end
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    property p_raise; ALARM_RAISE_I |=> ALARM_O && !DRIVE_ENABLE_O; endproperty
    a_raise: assert property (p_raise) else $error("Alarm raise not taken.");
    property p_gpi;
        age_q == 2'h3 && !VARIABLE_IO_I && !$past(VARIABLE_IO_I) && !$past(VARIABLE_IO_I, 2)
            |-> GP_INPUT_O == $past(EN_PIN_I, 2);
    endproperty
    a_gpi: assert property (p_gpi) else $error("Input level not two samples late.");
    property p_noedge; $stable(GP_INPUT_O) [*4] ##0 ALARM_O |=> ALARM_O; endproperty
    a_noedge: assert property (p_noedge) else $error("Alarm cleared with no edge.");
    property p_en_alarm; $rose(DRIVE_ENABLE_O) |-> !ALARM_O; endproperty
    a_en_alarm: assert property (p_en_alarm) else $error("Enable during alarm.");
    property p_en_hw; hw_q |-> !$rose(DRIVE_ENABLE_O); endproperty
    a_en_hw: assert property (p_en_hw) else $error("Enable with hardware enable set.");
    property p_usage3; u3_q && ALARM_O |=> ALARM_O; endproperty
    a_usage3: assert property (p_usage3) else $error("Clear with usage three.");
    property p_speed; spd_q && ALARM_O |=> ALARM_O; endproperty
    a_speed: assert property (p_speed) else $error("Clear in speed change mode.");
    property p_status;
        PSEL_I && !PENABLE_I && !PWRITE_I && PADDR_I == `ACI_OFF_STATUS |=>
            PRDATA_O[1:0] == {$past(DRIVE_ENABLE_O), $past(ALARM_O)} && PRDATA_O[3] == $past(u3_q)
            && PRDATA_O[11:4] == ($past(GP_INPUT_O) ? `ACI_CHAR_H : `ACI_CHAR_L);
    endproperty
    a_status: assert property (p_status) else $error("Status word wrong.");
endmodule
bind alarm_clear_input alarm_clear_input_props props_u (
    .MCLK_I(MCLK_I), .RESET_I(RESET_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
    .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O),
    .EN_PIN_I(EN_PIN_I), .VARIABLE_IO_I(VARIABLE_IO_I), .ALARM_RAISE_I(ALARM_RAISE_I),
    .ALARM_O(ALARM_O), .DRIVE_ENABLE_O(DRIVE_ENABLE_O), .GP_INPUT_O(GP_INPUT_O));

// ==== verif/alarm_switch_model.sv ====
`timescale 1ns/1ps
module alarm_switch_model (
    // Clock
    input  wire logic MCLK_I,
    // Contact level, low while current flows
    output logic      contact_o
);
    // An unwired contact reads open, so the idle level is high.
    initial contact_o = 1'b1;
    task automatic move(input logic closed, input int hold);
        @(posedge MCLK_I);
        contact_o <= ~closed;
        repeat (hold) @(negedge MCLK_I);
    endtask
endmodule

// ==== verif/alarm_clear_input_test.sv ====
`timescale 1ns/1ps
`include "alarm_clear_map.svh"
module alarm_clear_input_test;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        serr;
    logic        berr;
    logic [3:0]  dir = 4'h0;
    logic        varo = 1'b0;
    logic        raise = 1'b0;
    logic        alarm;
    logic        en;
    logic        gpi;
    logic        contact;
    int          fails = 0;
    int          samples_checked = 0;
    always #20 clk = ~clk;
    alarm_switch_model sw_u (.MCLK_I(clk), .contact_o(contact));
    alarm_clear_input dut_u (
        .MCLK_I(clk), .RESET_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(serr), .EN_PIN_I(contact), .IO_PIN_I({contact, 3'b101}),
        .IO_DIR_IN_I(dir), .VARIABLE_IO_I(varo), .ALARM_RAISE_I(raise), .ALARM_O(alarm),
        .DRIVE_ENABLE_O(en), .GP_INPUT_O(gpi));
    // ----
    // Checking and bus tasks
    // ----
    task print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        q = prdata;
        berr = serr;
        if (n == 16) begin
            fails++;
            print_verdict();
        end
        {psel, pen} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, q, exp);
    endtask
    task automatic wait_on(input logic sel_en, input logic v);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while ((sel_en ? en : alarm) !== v && n < 30);
        chk(sel_en ? "enable" : "alarm", sel_en ? en : alarm, v);
        if (n == 30) print_verdict();
    endtask
    task pulse;
        @(posedge clk);
        raise <= 1'b1;
        @(posedge clk);
        raise <= 1'b0;
    endtask
    // ----
    // Scenarios
    // ----
    task s_reset_vals;
        rd(`ACI_OFF_USAGE, 32'h43, "usage");
        rd(`ACI_OFF_REPLY, 32'h33, "reply");
        rd(`ACI_OFF_STATUS, 32'h48a, "status");
        rd(`ACI_OFF_HWEN, 32'h0, "hwen");
    endtask
    task automatic s_gain_save;
        logic [31:0] g [3] = '{32'h8000, 32'h7fff, 32'hffff8001};
        logic [31:0] e [3] = '{32'hffff8001, 32'h7fff, 32'hffff8001};
        for (int i = 0; i < 3; i++) begin
            wr(`ACI_OFF_GAIN, g[i]);
            rd(`ACI_OFF_GAIN, e[i], "gain");
        end
        wr(`ACI_OFF_GAIN, 32'h0bb8);
        wr(`ACI_OFF_CTRL, 32'h1);
        wr(`ACI_OFF_GAIN, 32'h0064);
        rd(`ACI_OFF_SAVED, 32'h0bb80043, "saved");
    endtask
    task automatic s_clear(input logic [1:0] u, input logic hw);
        logic act;
        act = (u == 2'h1);
        wr(`ACI_OFF_USAGE, {26'h1, 4'h0, u});
        sw_u.move(act, 4);
        pulse();
        repeat (10) @(negedge clk);
        chk("alarm held", alarm, 1'b1);
        sw_u.move(!act, 10);
        chk("alarm at rest", alarm, 1'b1);
        sw_u.move(act, 0);
        wait_on(1'b0, 1'b0);
        chk("enable early", en, 1'b0);
        sw_u.move(!act, 0);
        if (hw) begin
            repeat (10) @(negedge clk);
            chk("enable held", en, 1'b0);
        end else begin
            wait_on(1'b1, 1'b1);
        end
    endtask
    task automatic s_modes;
        logic [7:0] m [5] = '{8'h0c, 8'h0d, 8'h0e, 8'h11, 8'h12};
        for (int i = 0; i < 5; i++) begin
            wr(`ACI_OFF_USAGE, 32'h41);
            wr(`ACI_OFF_MODE, {24'h0, m[i]});
            rd(`ACI_OFF_USAGE, i == 0 ? 32'h41 : 32'h43, "usage after mode");
        end
        wr(`ACI_OFF_USAGE, 32'h41);
        sw_u.move(1'b0, 4);
        wr(`ACI_OFF_CTRL, 32'h2);
        @(negedge clk);
        chk("raise by write", {alarm, en}, 2'b10);
        sw_u.move(1'b1, 10);
        sw_u.move(1'b0, 10);
        chk("alarm in speed mode", alarm, 1'b1);
        wr(`ACI_OFF_MODE, 32'h0);
    endtask
    task s_hold;
        wr(`ACI_OFF_HWEN, 32'h1);
        rd(`ACI_OFF_USAGE, 32'h43, "usage after hwen");
        s_clear(2'h1, 1'b1);
        wr(`ACI_OFF_HWEN, 32'h0);
    endtask
    task s_variable;
        @(posedge clk);
        varo <= 1'b1;
        dir <= 4'h8;
        wr(`ACI_OFF_USAGE, 32'h43);
        wr(`ACI_OFF_USAGE, 32'h23);
        rd(`ACI_OFF_USAGE, 32'h43, "refused point");
        wr(`ACI_OFF_USAGE, 32'h42);
        rd(`ACI_OFF_REPLY, 32'h3234, "variable reply");
        s_clear(2'h2, 1'b0);
        @(posedge clk);
        varo <= 1'b0;
        dir <= 4'h0;
        rd(12'h020, 32'h0, "unmapped data");
        chk("unmapped error", berr, 1'b1);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        s_reset_vals();
        s_gain_save();
        s_clear(2'h1, 1'b0);
        s_clear(2'h2, 1'b0);
        s_modes();
        s_hold();
        s_variable();
        print_verdict();
    end
endmodule
